// ---- hdl/safety_io_pkg.sv ----
// Constants, register map and enumerations of the dual channel safety I/O
package safety_io_pkg;
    // Clock and time base
    localparam int CLK_PERIOD_NS = 25;
    localparam int US_NS = 1000;
    localparam int CYCLES_PER_US = (US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int US_PER_MS = 1000;
    // Output off-pulse schedule, in milliseconds
    localparam int PULSE_PERIOD_MS = 500;
    localparam int PULSE_STAGGER_MS = 250;

    // Register bus widths and word addresses
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;
    localparam logic [3:0] ADDR_CONFIG = 4'h0;
    localparam logic [3:0] ADDR_FILTER_US = 4'h1;
    localparam logic [3:0] ADDR_MISMATCH_MS = 4'h2;
    localparam logic [3:0] ADDR_PULSE_OFF_US = 4'h3;
    localparam logic [3:0] ADDR_STATUS = 4'h4;

    // Configuration register fields
    localparam int CFG_IN_SEL_LSB = 0;
    localparam int CFG_IN_SEL_W = 3;
    localparam int CFG_OUT_SEL_LSB = 3;
    localparam int CFG_OUT_SEL_W = 4;
    localparam int CFG_NET_MODE_BIT = 7;
    localparam int CFG_AND_AXES_BIT = 8;
    localparam int CFG_W = 9;

    // Status register fields
    localparam int ST_FILT1_BIT = 0;
    localparam int ST_FILT2_BIT = 1;
    localparam int ST_MISMATCH_BIT = 2;
    localparam int ST_OUT1_BIT = 3;
    localparam int ST_OUT2_BIT = 4;
    localparam int ST_SEL_STATUS_BIT = 5;

    // Setting limits and reset values
    localparam int FILTER_W = 15;
    localparam logic [14:0] FILTER_MIN_US = 15'h03E8;
    localparam logic [14:0] FILTER_MAX_US = 15'h7D00;
    localparam logic [14:0] FILTER_RESET_US = 15'h03E8;
    localparam int MISMATCH_W = 16;
    localparam logic [15:0] MISMATCH_MAX_MS = 16'hEA60;
    localparam logic [15:0] MISMATCH_RESET_MS = 16'h0064;
    localparam int PULSE_W = 11;
    localparam logic [10:0] PULSE_MIN_US = 11'h1F4;
    localparam logic [10:0] PULSE_MAX_US = 11'h7D0;
    localparam logic [10:0] PULSE_RESET_US = 11'h1F4;
    localparam logic [8:0] CONFIG_RESET = 9'h000;

    // Safety commands that the input pair can drive
    localparam int NUM_CMD = 8;
    localparam logic [2:0] CMD_TORQUE_OFF = 3'h0;
    localparam logic [2:0] CMD_STOP1 = 3'h1;
    localparam logic [2:0] CMD_STOP2 = 3'h2;
    localparam logic [2:0] CMD_SPEED_LIMIT1 = 3'h3;
    localparam logic [2:0] CMD_POS_DIRECTION = 3'h4;
    localparam logic [2:0] CMD_NEG_DIRECTION = 3'h5;
    localparam logic [2:0] CMD_POSITION_LIMIT = 3'h6;
    localparam logic [2:0] CMD_TORQUE_LIMIT1 = 3'h7;

    // Status monitors that the output pair can show
    localparam int NUM_STAT = 10;
    localparam logic [3:0] STAT_TORQUE_OFF = 4'h0;
    localparam logic [3:0] STAT_STOP1 = 4'h1;
    localparam logic [3:0] STAT_STOP2 = 4'h2;
    localparam logic [3:0] STAT_SPEED_LIMIT1 = 4'h3;
    localparam logic [3:0] STAT_SAFE_SPEED = 4'h4;
    localparam logic [3:0] STAT_BRAKE_CONTROL = 4'h5;
    localparam logic [3:0] STAT_POS_DIRECTION = 4'h6;
    localparam logic [3:0] STAT_NEG_DIRECTION = 4'h7;
    localparam logic [3:0] STAT_POSITION_LIMIT = 4'h8;
    localparam logic [3:0] STAT_TORQUE_LIMIT1 = 4'h9;
endpackage : safety_io_pkg

// ---- hdl/input_filter.sv ----
// Noise filter for one safety input channel, counted in microseconds
module input_filter
    import safety_io_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Time base and setting
    input wire logic tick_us,
    input wire logic [14:0] limit_us,
    // Data
    input wire logic raw,
    output logic level
);
    logic [14:0] count;
    logic [14:0] next_count;
    logic next_level;

    // Count while raw differs; any return to the held level restarts it
    always_comb begin
        next_count = count;
        next_level = level;
        if (raw == level) begin
            next_count = 15'h0000;
        end else if (tick_us) begin
            if (count >= limit_us) begin
                next_level = raw;
                next_count = 15'h0000;
            end else begin
                next_count = count + 15'h0001;
            end
        end
    end

    // Level resets low, which reads as a commanded safety function
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count <= 15'h0000;
            level <= 1'b0;
        end else begin
            count <= next_count;
            level <= next_level;
        end
    end
endmodule : input_filter

// ---- hdl/off_pulse.sv ----
// One-shot off-pulse timer for one output channel, length in microseconds
module off_pulse
    import safety_io_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Control
    input wire logic tick_us,
    input wire logic start,
    input wire logic [10:0] len_us,
    // State
    output logic active
);
    logic [10:0] count;
    logic [10:0] next_count;
    logic next_active;

    // Start loads the length; the pulse ends when the count runs out
    always_comb begin
        next_count = count;
        next_active = active;
        if (start) begin
            next_count = len_us;
            next_active = 1'b1;
        end else if (active && tick_us) begin
            if (count <= 11'h001) begin
                next_active = 1'b0;
                next_count = 11'h000;
            end else begin
                next_count = count - 11'h001;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count <= 11'h000;
            active <= 1'b0;
        end else begin
            count <= next_count;
            active <= next_active;
        end
    end
endmodule : off_pulse

// ---- hdl/safety_io.sv ----
// Top of the dual channel safety input and output stage
// Notes on behaviour
// - One input point made of two redundant channels carrying one command.
// - Channels may disagree only up to a set time of 0 to 60000 ms.
// - Each input passes a noise filter of 1 to 32 ms, microsecond steps.
// - Off test pulses up to 1 ms at 1 to 25 Hz change no command.
// - One output point made of two redundant channels carrying one status.
// - While the status is on, short off-pulses repeat on both channels.
// - Off-pulse lasts 0.5 to 2.0 ms as set, repeating at least per second.
// - The two output channels are never pulsed off at the same time.
// - Input select assigns the pair to one of eight safety commands.
// - Output select assigns one of ten status monitors to the pair.
// - Output shows axis A alone or the AND of axes A, B and C.
// - Input on axis A activates the assigned function on axis A.
// - Connector inputs are used only when network control is off.
// - Under network control commands come from the network, not pins.
// - Status also goes to the network; connector outputs keep working.
module safety_io
    import safety_io_pkg::*;
(
    // Clock and reset
    input wire logic REF_CLK,
    input wire logic RST_N,
    // Register port
    input wire logic [3:0] ADDR,
    input wire logic [15:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [15:0] RDATA,
    // Connector input pair, from pins
    input wire logic IN_CH1,
    input wire logic IN_CH2,
    // Commands from the network
    input wire logic [7:0] NET_CMD,
    // Status monitors of axes A, B and C
    input wire logic [9:0] STATUS_A,
    input wire logic [9:0] STATUS_B,
    input wire logic [9:0] STATUS_C,
    // Commands to axis A
    output logic [7:0] AXIS_A_CMD,
    // Connector output pair and network status
    output logic OUT_CH1,
    output logic OUT_CH2,
    output logic NET_STATUS,
    output logic MISMATCH_ERR
);
    // Configuration state
    logic [8:0] config_reg;
    logic [14:0] filter_us;
    logic [15:0] mismatch_ms;
    logic [10:0] pulse_us;
    logic [8:0] next_config_reg;
    logic [14:0] next_filter_us;
    logic [15:0] next_mismatch_ms;
    logic [10:0] next_pulse_us;
    logic [15:0] next_rdata;
    logic [15:0] status_word;

    // Decoded configuration
    logic [2:0] in_sel;
    logic [3:0] out_sel;
    logic net_mode;
    logic and_axes;

    // Time base
    logic [5:0] pre_count;
    logic [9:0] us_count;
    logic [5:0] next_pre_count;
    logic [9:0] next_us_count;
    logic tick_us;
    logic tick_ms;

    // Input path
    logic [1:0] sync1;
    logic [1:0] sync2;
    logic filt1;
    logic filt2;
    logic [15:0] mm_count;
    logic [15:0] next_mm_count;
    logic next_mismatch_err;
    logic clear_err;
    logic cmd_active;
    logic [7:0] next_axis_cmd;

    // Output path
    logic sel_status;
    logic [8:0] period_ms;
    logic [8:0] next_period_ms;
    logic start1;
    logic start2;
    logic pulse1;
    logic pulse2;
    logic next_out1;
    logic next_out2;

    assign in_sel = config_reg[CFG_IN_SEL_LSB +: CFG_IN_SEL_W];
    assign out_sel = config_reg[CFG_OUT_SEL_LSB +: CFG_OUT_SEL_W];
    assign net_mode = config_reg[CFG_NET_MODE_BIT];
    assign and_axes = config_reg[CFG_AND_AXES_BIT];

    // Register writes; settings are clamped to their legal ranges
    always_comb begin
        next_config_reg = config_reg;
        next_filter_us = filter_us;
        next_mismatch_ms = mismatch_ms;
        next_pulse_us = pulse_us;
        clear_err = 1'b0;
        if (WR) begin
            unique case (ADDR)
                ADDR_CONFIG: next_config_reg = WDATA[CFG_W-1:0];
                ADDR_FILTER_US: begin
                    if (WDATA[14:0] < FILTER_MIN_US) begin
                        next_filter_us = FILTER_MIN_US;
                    end else if (WDATA[14:0] > FILTER_MAX_US) begin
                        next_filter_us = FILTER_MAX_US;
                    end else begin
                        next_filter_us = WDATA[14:0];
                    end
                end
                ADDR_MISMATCH_MS: begin
                    if (WDATA > MISMATCH_MAX_MS) begin
                        next_mismatch_ms = MISMATCH_MAX_MS;
                    end else begin
                        next_mismatch_ms = WDATA;
                    end
                end
                ADDR_PULSE_OFF_US: begin
                    if (WDATA[10:0] < PULSE_MIN_US || WDATA[15:11] != 5'h00) begin
                        next_pulse_us = (WDATA[15:11] != 5'h00) ?
                            PULSE_MAX_US : PULSE_MIN_US;
                    end else if (WDATA[10:0] > PULSE_MAX_US) begin
                        next_pulse_us = PULSE_MAX_US;
                    end else begin
                        next_pulse_us = WDATA[10:0];
                    end
                end
                ADDR_STATUS: clear_err = WDATA[ST_MISMATCH_BIT];
                default: ;
            endcase
        end
    end

    // Status word seen by software; unmapped addresses read zero
    always_comb begin
        status_word = 16'h0000;
        status_word[ST_FILT1_BIT] = filt1;
        status_word[ST_FILT2_BIT] = filt2;
        status_word[ST_MISMATCH_BIT] = MISMATCH_ERR;
        status_word[ST_OUT1_BIT] = OUT_CH1;
        status_word[ST_OUT2_BIT] = OUT_CH2;
        status_word[ST_SEL_STATUS_BIT] = sel_status;
        next_rdata = 16'h0000;
        if (RD) begin
            unique case (ADDR)
                ADDR_CONFIG: next_rdata = {7'h00, config_reg};
                ADDR_FILTER_US: next_rdata = {1'b0, filter_us};
                ADDR_MISMATCH_MS: next_rdata = mismatch_ms;
                ADDR_PULSE_OFF_US: next_rdata = {5'h00, pulse_us};
                ADDR_STATUS: next_rdata = status_word;
                default: next_rdata = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            config_reg <= CONFIG_RESET;
            filter_us <= FILTER_RESET_US;
            mismatch_ms <= MISMATCH_RESET_MS;
            pulse_us <= PULSE_RESET_US;
            RDATA <= 16'h0000;
        end else begin
            config_reg <= next_config_reg;
            filter_us <= next_filter_us;
            mismatch_ms <= next_mismatch_ms;
            pulse_us <= next_pulse_us;
            RDATA <= next_rdata;
        end
    end

    // Microsecond and millisecond ticks from the reference clock
    always_comb begin
        tick_us = (pre_count == 6'(CYCLES_PER_US - 1));
        tick_ms = tick_us && (us_count == 10'(US_PER_MS - 1));
        next_pre_count = tick_us ? 6'h00 : pre_count + 6'h01;
        next_us_count = us_count;
        if (tick_ms) begin
            next_us_count = 10'h000;
        end else if (tick_us) begin
            next_us_count = us_count + 10'h001;
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            pre_count <= 6'h00;
            us_count <= 10'h000;
        end else begin
            pre_count <= next_pre_count;
            us_count <= next_us_count;
        end
    end

    // Two-stage synchronisers for the connector pins
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            sync1 <= 2'h0;
            sync2 <= 2'h0;
        end else begin
            sync1 <= {IN_CH2, IN_CH1};
            sync2 <= sync1;
        end
    end

    // Filter of at least 1 ms also hides test off-pulses of up to 1 ms
    input_filter u_filter1 (
        .clk(REF_CLK),
        .rst_n(RST_N),
        .tick_us(tick_us),
        .limit_us(filter_us),
        .raw(sync2[0]),
        .level(filt1)
    );

    input_filter u_filter2 (
        .clk(REF_CLK),
        .rst_n(RST_N),
        .tick_us(tick_us),
        .limit_us(filter_us),
        .raw(sync2[1]),
        .level(filt2)
    );

    // Mismatch timer; the error is sticky and its set beats a clear
    always_comb begin
        next_mm_count = mm_count;
        next_mismatch_err = MISMATCH_ERR;
        if (clear_err) begin
            next_mismatch_err = 1'b0;
        end
        if (net_mode || filt1 == filt2) begin
            next_mm_count = 16'h0000;
        end else if (tick_ms && mm_count != 16'hFFFF) begin
            next_mm_count = mm_count + 16'h0001;
        end
        if (!net_mode && filt1 != filt2 && mm_count > mismatch_ms) begin
            next_mismatch_err = 1'b1;
        end
    end

    // Command asserted when any channel is off; error forces it too
    always_comb begin
        cmd_active = !(filt1 && filt2) || MISMATCH_ERR;
        next_axis_cmd = 8'h00;
        if (net_mode) begin
            next_axis_cmd = NET_CMD;
        end else begin
            next_axis_cmd[in_sel] = cmd_active;
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            mm_count <= 16'h0000;
            MISMATCH_ERR <= 1'b0;
            AXIS_A_CMD <= 8'h00;
        end else begin
            mm_count <= next_mm_count;
            MISMATCH_ERR <= next_mismatch_err;
            AXIS_A_CMD <= next_axis_cmd;
        end
    end

    // Status selection; codes past the last monitor read as off
    always_comb begin
        sel_status = 1'b0;
        if (out_sel < 4'(NUM_STAT)) begin
            if (and_axes) begin
                sel_status = STATUS_A[out_sel] && STATUS_B[out_sel] &&
                    STATUS_C[out_sel];
            end else begin
                sel_status = STATUS_A[out_sel];
            end
        end
    end

    // Pulse schedule: channel 1 at period start, channel 2 half way
    always_comb begin
        next_period_ms = period_ms;
        if (!sel_status) begin
            next_period_ms = 9'h000;
        end else if (tick_ms) begin
            if (period_ms == 9'(PULSE_PERIOD_MS - 1)) begin
                next_period_ms = 9'h000;
            end else begin
                next_period_ms = period_ms + 9'h001;
            end
        end
        start1 = sel_status && tick_ms && period_ms == 9'h000;
        start2 = sel_status && tick_ms &&
            period_ms == 9'(PULSE_STAGGER_MS);
    end

    // Off time capped at 2 ms, far below the stagger, so never overlap
    off_pulse u_pulse1 (
        .clk(REF_CLK),
        .rst_n(RST_N),
        .tick_us(tick_us),
        .start(start1),
        .len_us(pulse_us),
        .active(pulse1)
    );

    off_pulse u_pulse2 (
        .clk(REF_CLK),
        .rst_n(RST_N),
        .tick_us(tick_us),
        .start(start2),
        .len_us(pulse_us),
        .active(pulse2)
    );

    // Outputs on only with the status on and outside their own pulse
    always_comb begin
        next_out1 = sel_status && !pulse1 && !start1;
        next_out2 = sel_status && !pulse2 && !start2;
    end

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            period_ms <= 9'h000;
            OUT_CH1 <= 1'b0;
            OUT_CH2 <= 1'b0;
            NET_STATUS <= 1'b0;
        end else begin
            period_ms <= next_period_ms;
            OUT_CH1 <= next_out1;
            OUT_CH2 <= next_out2;
            NET_STATUS <= sel_status;
        end
    end
endmodule : safety_io

// ---- bench/safety_io_asserts.sv ----
// Concurrent checks on the ports of the safety I/O stage
module safety_io_checker
    import safety_io_pkg::*;
(
    // Clock and reset
    input wire logic REF_CLK,
    input wire logic RST_N,
    // Register port
    input wire logic [3:0] ADDR,
    input wire logic [15:0] WDATA,
    input wire logic WR,
    // Pins and axis side
    input wire logic IN_CH1,
    input wire logic IN_CH2,
    input wire logic [7:0] NET_CMD,
    input wire logic [9:0] STATUS_A,
    input wire logic [7:0] AXIS_A_CMD,
    input wire logic OUT_CH1,
    input wire logic OUT_CH2,
    input wire logic NET_STATUS,
    input wire logic MISMATCH_ERR
);
    timeunit 1ns;
    timeprecision 1ps;
    // Pulse bounds allow one microsecond tick of slack below 0.5 ms and 2.5 us above 2 ms
    localparam int PULSE_LO = 19960;
    localparam int PULSE_HI = 80100;
    localparam int GAP_MAX = 40000000;
    localparam int FILT_MIN = 39000;
    int lo1, lo2, hi1, s1, s2;

    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (!RST_N);

    // Run lengths of output phases and of steady raw inputs
    always_ff @(posedge REF_CLK) begin
        lo1 <= (OUT_CH1 || !NET_STATUS) ? 0 : lo1 + 1;
        lo2 <= (OUT_CH2 || !NET_STATUS) ? 0 : lo2 + 1;
        hi1 <= (!OUT_CH1 || !NET_STATUS) ? 0 : hi1 + 1;
        s1 <= $changed(IN_CH1) ? 0 : s1 + 1;
        s2 <= $changed(IN_CH2) ? 0 : s2 + 1;
    end

    property p_both_on;
        NET_STATUS && $past(NET_STATUS) |-> OUT_CH1 || OUT_CH2;
    endproperty
    a_both_on: assert property (p_both_on)
        else $error("both outputs off together");

    property p_off_quiet;
        !NET_STATUS && !$past(NET_STATUS) |-> !OUT_CH1 && !OUT_CH2;
    endproperty
    a_off_quiet: assert property (p_off_quiet)
        else $error("output on while status off");

    property p_pulse1;
        $rose(OUT_CH1) && $past(NET_STATUS) |-> lo1 >= PULSE_LO
            && lo1 <= PULSE_HI;
    endproperty
    a_pulse1: assert property (p_pulse1)
        else $error("channel 1 pulse length");

    property p_pulse2;
        $rose(OUT_CH2) && $past(NET_STATUS) |-> lo2 >= PULSE_LO
            && lo2 <= PULSE_HI;
    endproperty
    a_pulse2: assert property (p_pulse2)
        else $error("channel 2 pulse length");

    property p_repeat;
        NET_STATUS |-> hi1 < GAP_MAX;
    endproperty
    a_repeat: assert property (p_repeat)
        else $error("no off pulse within one second");

    property p_err_clear;
        $fell(MISMATCH_ERR) |-> $past(WR) && $past(ADDR) == ADDR_STATUS
            && $past(WDATA[2]);
    endproperty
    a_err_clear: assert property (p_err_clear)
        else $error("error dropped without clear");

    property p_axis_a;
        NET_STATUS |-> $past(STATUS_A) != 10'h000
            || $past(STATUS_A, 2) != 10'h000;
    endproperty
    a_axis_a: assert property (p_axis_a)
        else $error("status on with axis A all off");

    property p_filter;
        $changed(AXIS_A_CMD) && $past(RST_N, 4) && !$past(WR)
            && !$past(WR, 2)
            && !$past(WR, 3) && $past(NET_CMD) == $past(NET_CMD, 2)
            && $stable(MISMATCH_ERR)
            && $past(MISMATCH_ERR) == $past(MISMATCH_ERR, 2)
            |-> s1 > FILT_MIN || s2 > FILT_MIN;
    endproperty
    a_filter: assert property (p_filter)
        else $error("command changed too early");
endmodule : safety_io_checker

bind safety_io safety_io_checker u_chk (.*);

// ---- bench/safety_switch.sv ----
// Far-side safety switch with two contacts and a test pulse source
module safety_switch
    import safety_io_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Control from the bench
    input wire logic open_req,
    input wire logic pulse_go,
    input wire logic [15:0] pulse_len,
    // Output pair of the device, tolerated as is
    input wire logic out1,
    input wire logic out2,
    // Contact pair
    output logic ch1,
    output logic ch2
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt;
    int phase;

    // Off pulse on one contact, a gap, then the other contact
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            phase <= 0;
            cnt <= 0;
        end else if (phase == 0 ? pulse_go : cnt <= 1) begin
            phase <= (phase + 1) % 4;
            cnt <= pulse_len;
        end else if (phase != 0) begin
            cnt <= cnt - 1;
        end
    end

    // Both contacts carry one command; closed means energised
    // Pulse length kept under 1 ms by the bench
    assign ch1 = rst_n && !open_req && phase != 1;
    assign ch2 = rst_n && !open_req && phase != 3;
endmodule : safety_switch

// ---- bench/dual_channel_safety_io_bench.sv ----
// Self-checking bench of the dual channel safety I/O stage
module dual_channel_safety_io_bench
    import safety_io_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // Write then read table: address and data
    localparam int TA[10] = '{0, 1, 1, 2, 3, 3, 3, 1, 2, 3};
    localparam int TD[10] = '{'hFE00, 5, 'hFFFF, 'hFFFF, 'h100, 'h800,
        'h7FF, 1000, 0, 500};
    logic clk, rst_n, wr, rd, open_req, pulse_go;
    logic [3:0] addr;
    logic [15:0] wdata, pulse_len, rdata;
    logic [7:0] net_cmd, axis_cmd;
    logic [9:0] st_a, st_b, st_c;
    logic in1, in2, out1, out2, net_status, mis_err;
    logic [31:0] rng = 32'h0000002D;
    int regs[4] = '{0, 1000, 100, 500};
    int n_errors = 0;
    int samples_checked = 0;

    safety_io u_dut (.REF_CLK(clk), .RST_N(rst_n), .ADDR(addr),
        .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .IN_CH1(in1),
        .IN_CH2(in2), .NET_CMD(net_cmd), .STATUS_A(st_a), .STATUS_B(st_b),
        .STATUS_C(st_c), .AXIS_A_CMD(axis_cmd), .OUT_CH1(out1),
        .OUT_CH2(out2), .NET_STATUS(net_status), .MISMATCH_ERR(mis_err));
    safety_switch u_switch (.clk, .rst_n, .open_req, .pulse_go, .pulse_len,
        .out1, .out2, .ch1(in1), .ch2(in2));

    // Clock at 40 MHz
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    function automatic logic [31:0] xs();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction : xs

    // Model of the setting clamps; reserved config bits read 0
    function automatic int clamp(int a, int d);
        case (a)
            0: return d & 16'h01FF;
            1: return d < 1000 ? 1000 : (d > 32000 ? 32000 : d);
            2: return d > 60000 ? 60000 : d;
            default: return d < 500 ? 500 : (d > 2000 ? 2000 : d);
        endcase
    endfunction : clamp

    // Model of the selected status; codes above 9 read as off
    function automatic logic exp_stat(int s, logic both);
        if (s > 9) return 1'b0;
        return st_a[s] & (!both | (st_b[s] & st_c[s]));
    endfunction : exp_stat

    task automatic chk_word(logic [15:0] got, logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("FAIL t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk_word

    task automatic chk_bit(logic got, logic exp);
        chk_word(16'(got), 16'(exp));
    endtask : chk_bit

    task automatic reg_wr(logic [3:0] a, logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        if (a < 4'h4) regs[a] = clamp(a, d);
    endtask : reg_wr

    // Read data stand only in the cycle after the strobe
    task automatic reg_rd(logic [3:0] a, output logic [15:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask : reg_rd

    task automatic cyc(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc

    task automatic finish_test();
        $display("checked %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : finish_test

    // Watchdog, well past the longest expected run
    initial begin
        repeat (98000) @(posedge clk);
        n_errors++;
        finish_test();
    end

    initial begin
        logic [15:0] d;
        logic [31:0] r;
        int n, m, k;
        logic bad, e;
        rst_n = 1'b0;
        {wr, rd, open_req, pulse_go, addr, wdata, pulse_len} = 40'h0;
        {net_cmd, st_a, st_b, st_c} = 38'h0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        // Reset values, unmapped reads, clamped writes
        for (int a = 0; a < 6; a++) begin
            reg_rd(4'(a), d);
            chk_word(d, a < 4 ? 16'(regs[a]) : 16'h0000);
        end
        for (int i = 0; i < 10; i++) begin
            reg_wr(4'(TA[i]), 16'(TD[i]));
            reg_rd(4'(TA[i]), d);
            chk_word(d, 16'(regs[TA[i]]));
        end
        $display("registers done");
        // Every status code, axis A alone or ANDed
        for (int i = 0; i < 32; i++) begin
            reg_wr(4'h0, {7'h00, i[4], 1'b0, i[3:0], 3'h0});
            {st_c, st_b, st_a} <= 30'(xs());
            cyc(3);
            e = exp_stat(i & 15, i[4]);
            chk_bit(net_status, e);
            chk_bit(out1, e);
            chk_bit(out2, e);
        end
        $display("output select done");
        // Network mode: pins open yet commands follow the network
        open_req <= 1'b1;
        reg_wr(4'h0, 16'h0080);
        for (int i = 0; i < 8; i++) begin
            r = xs();
            {st_a, net_cmd} <= r[17:0];
            cyc(3);
            chk_word(16'(axis_cmd), 16'(r[7:0]));
            chk_bit(net_status, r[8]);
            chk_bit(out1, r[8]);
        end
        $display("network mode done");
        // Open contacts give the selected command on axis A
        for (int s = 0; s < 8; s++) begin
            reg_wr(4'h0, 16'(s));
            cyc(3);
            chk_word(16'(axis_cmd), 16'(1 << s));
        end
        reg_wr(4'h0, 16'h0003);
        st_a <= 10'h001;
        open_req <= 1'b0;
        // Let the outputs settle on before timing the pulse
        cyc(3);
        fork
            begin
                n = 0;
                while (axis_cmd[3] !== 1'b0 && n < 50000) begin
                    cyc(1);
                    n++;
                end
                chk_bit(n >= 40000 && n < 42000, 1'b1);
            end
            begin
                m = 0;
                k = 0;
                bad = 1'b0;
                while (out1 !== 1'b0 && m < 45000) begin
                    cyc(1);
                    m++;
                end
                while (out1 === 1'b0 && k < 90000) begin
                    if (out2 !== 1'b1) bad = 1'b1;
                    cyc(1);
                    k++;
                end
                chk_bit(k >= 19960 && k <= 20080, 1'b1);
                chk_bit(bad, 1'b0);
            end
        join
        $display("filter and off pulse done");
        // Test pulses of 200 us on each contact change nothing
        pulse_len <= 16'h1F40;
        pulse_go <= 1'b1;
        @(posedge clk);
        pulse_go <= 1'b0;
        bad = 1'b0;
        repeat (25000) begin
            cyc(1);
            if (axis_cmd !== 8'h00 || mis_err !== 1'b0) bad = 1'b1;
        end
        chk_bit(bad, 1'b0);
        $display("test pulses done");
        // Status off: both outputs low, status word settled
        st_a <= 10'h000;
        cyc(3);
        chk_bit(out1, 1'b0);
        chk_bit(out2, 1'b0);
        reg_rd(ADDR_STATUS, d);
        chk_word(d, 16'h0003);
        $display("status off done");
        finish_test();
    end
endmodule : dual_channel_safety_io_bench
